/* File: ost_defs.svh */
// Purpose: constants for the output synchronisation parameter set
// Assumes: 50 MHz clock, subentry numbers used as register addresses
// Notes:   definitions only
`ifndef OST_DEFS_SVH
`define OST_DEFS_SVH
`define OST_CLK_HZ        1000000000/20
`define OST_NS_PER_S      1000000000
`define OST_NS_PER_CLK    (`OST_NS_PER_S/(`OST_CLK_HZ))
`define OST_SUB_COUNT     8'h00
`define OST_SUB_MODE      8'h01
`define OST_SUB_CYCLE     8'h02
`define OST_SUB_SHIFT     8'h03
`define OST_SUB_SUPP      8'h04
`define OST_SUB_MINCYC    8'h05
`define OST_SUB_CALC      8'h06
`define OST_SUB_CMD       8'h08
`define OST_SUB_DELAY     8'h09
`define OST_SUB_MISSED    8'h0b
`define OST_SUB_OVERRUN   8'h0c
`define OST_SUB_SHORT     8'h0d
`define OST_SUB_FAULT     8'h20
`define OST_COUNT_VAL     8'h20
`define OST_CYCLE_RST     32'h000186a0
`define OST_SUPP_VAL      16'hc007
`define OST_CMD_STOP      16'h0000
`define OST_CMD_START     16'h0001
`define OST_MODE_MAX      32'h00000003
`endif

/* File: ost_pkg.sv */
// Purpose: types of the output synchronisation parameter set
// Assumes: nothing
// Notes:   request and answer of the dictionary port travel as structs
package ost_pkg;
   typedef enum logic [1:0] {OST_FREE, OST_BUF, OST_PULSE_A, OST_PULSE_B} ost_mode_t;
   typedef enum logic {OST_IDLE, OST_MEAS} ost_meas_t;
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  sub;
      logic [31:0] wdata;
   } ost_od_req_t;
   typedef struct packed {
      logic        ack;
      logic        abort;
      logic [31:0] rdata;
   } ost_od_rsp_t;
endpackage

/* File: ost_period_timer.sv */
// Purpose: local free-running cycle timer, period given in ns
// Assumes: period of at least one clock
// Notes:   restarts whenever run drops
`timescale 1ns/1ns
`include "ost_defs.svh"
module ost_period_timer
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        run,
   input  wire logic [31:0] period_ns,
   output logic             tick
);
   localparam logic [31:0] NS = 32'(`OST_NS_PER_CLK);
   logic [31:0] acc_q;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         acc_q <= 32'h0;
         tick  <= 1'b0;
      end
      else if (!run)
      begin
         acc_q <= 32'h0;
         tick  <= 1'b0;
      end
      else if (acc_q + NS >= period_ns)
      begin
         acc_q <= 32'h0;
         tick  <= 1'b1;
      end
      else
      begin
         acc_q <= acc_q + NS;
         tick  <= 1'b0;
      end
   end
endmodule

/* File: ost_event_cnt.sv */
// Purpose: diagnostic event counter
// Assumes: nothing
// Notes:   saturates, so a wrap never hides a long fault burst
`timescale 1ns/1ns
module ost_event_cnt #(parameter int W = 16)
(
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         inc,
   output logic [W-1:0]      count
);
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         count <= '0;
      else if (inc && !(&count))
         count <= count + 1'b1;
   end
endmodule

/* File: ost_output_sync.sv */
// Purpose: output synchronisation parameter set with measurement and diagnostics
// Assumes: dictionary accesses arrive as one-cycle rd or wr strobes
// Notes:   answers one cycle after each strobe
`timescale 1ns/1ns
`include "ost_defs.svh"
////////////////////////////////////////////////////////////////////////////////
module ost_output_sync
   import ost_pkg::*;
#(
   parameter int CNT_W = 16
)
(
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire ost_od_req_t  od_req,
   output ost_od_rsp_t       od_rsp,
   input  wire logic         running_state,
   input  wire logic         output_buffer_event,
   input  wire logic         shared_time_pulse_a,
   input  wire logic         shared_time_pulse_b,
   input  wire logic         cycle_done,
   output logic              outputs_drive,
   output logic              sync_fault,
   output logic              meas_active
);
   localparam logic [31:0] NS = 32'(`OST_NS_PER_CLK);

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [31:0] max32(input logic [31:0] a, input logic [31:0] b);
      max32 = (a > b) ? a : b;
   endfunction

   function automatic logic is_sub(input logic [7:0] s, input logic [7:0] want);
      is_sub = (s == want);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   ost_mode_t          mode_q;
   ost_meas_t          meas_q;
   logic [31:0]        cycle_q;
   logic [15:0]        cmd_q;
   logic [31:0]        shift_q;
   logic [31:0]        mincyc_q;
   logic [31:0]        calc_q;
   logic [31:0]        delay_q;
   logic [31:0]        elapsed_q [3];
   logic [2:0]         restart;
   logic [CNT_W-1:0]   cnt [3];
   logic [2:0]         inc;
   logic               tick;
   logic               trig;
   logic               shared;
   logic               busy_q;
   logic               started_q;
   logic               got_buf_q;
   logic               a_seen_q;
   logic               wr_mode_ok;
   logic               wr_cmd_ok;
   logic               start_meas;
   logic [31:0]        rd_val;
   logic               rd_known;

   ////////////////////////////////////////////////////////////////////////////
   // configuration writes
   assign wr_mode_ok = od_req.wr && is_sub(od_req.sub, `OST_SUB_MODE)
                       && (od_req.wdata <= `OST_MODE_MAX);
   assign wr_cmd_ok  = od_req.wr && is_sub(od_req.sub, `OST_SUB_CMD)
                       && (od_req.wdata[31:1] == 31'h0);
   assign start_meas = wr_cmd_ok && od_req.wdata[0];

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         mode_q <= OST_FREE;
      else if (wr_mode_ok)
         mode_q <= ost_mode_t'(od_req.wdata[1:0]);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         cycle_q <= `OST_CYCLE_RST;
      else if (od_req.wr && is_sub(od_req.sub, `OST_SUB_CYCLE))
         cycle_q <= od_req.wdata;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         cmd_q <= `OST_CMD_STOP;
      else if (wr_cmd_ok)
         cmd_q <= od_req.wdata[15:0];
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         meas_q <= OST_IDLE;
      else if (wr_cmd_ok)
      begin
         unique case (meas_q)
            OST_IDLE: meas_q <= od_req.wdata[0] ? OST_MEAS : OST_IDLE;
            OST_MEAS: meas_q <= od_req.wdata[0] ? OST_MEAS : OST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // cycle trigger
   // local timer period
   ost_period_timer u_timer
   (
      .clk       (clk),
      .nrst      (nrst),
      .run       (mode_q == OST_FREE),
      .period_ns (cycle_q),
      .tick      (tick)
   );

   assign shared = (mode_q == OST_PULSE_A) || (mode_q == OST_PULSE_B);

   always_comb
   begin
      unique case (mode_q)
         OST_FREE:    trig = tick;
         OST_BUF:     trig = output_buffer_event;
         OST_PULSE_A: trig = shared_time_pulse_a;
         OST_PULSE_B: trig = shared_time_pulse_b;
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         outputs_drive <= 1'b0;
      else
         outputs_drive <= trig;
   end

   // a new cycle keeps busy set even if done lands with it
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         busy_q    <= 1'b0;
         started_q <= 1'b0;
      end
      else
      begin
         busy_q    <= trig | (busy_q & ~cycle_done);
         started_q <= started_q | trig;
      end
   end

   // buffer event seen since the last pulse A, set wins
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         got_buf_q <= 1'b0;
         a_seen_q  <= 1'b0;
      end
      else
      begin
         got_buf_q <= output_buffer_event | (got_buf_q & ~shared_time_pulse_a);
         a_seen_q  <= a_seen_q | shared_time_pulse_a;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // elapsed ns since pulse A, pulse B and cycle start; saturating
   assign restart = {trig, shared_time_pulse_b, shared_time_pulse_a};

   for (genvar i = 0; i < 3; i++)
   begin : g_elapsed
      always_ff @(posedge clk or negedge nrst)
      begin
         if (!nrst)
            elapsed_q[i] <= 32'h0;
         else if (restart[i])
            elapsed_q[i] <= 32'h0;
         else if (elapsed_q[i] <= ~NS)
            elapsed_q[i] <= elapsed_q[i] + NS;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // measured maxima
   // keep largest values
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         shift_q <= 32'h0;
         delay_q <= 32'h0;
      end
      else if (start_meas)
      begin
         shift_q <= 32'h0;
         delay_q <= 32'h0;
      end
      else if (meas_q == OST_MEAS && trig && shared)
      begin
         // pulse A to drive, a pulse in this cycle is no shift
         shift_q <= max32(shift_q, shared_time_pulse_a ? 32'h0 : elapsed_q[0]);
         // pulse B to drive, not the time since the previous pulse B
         if (mode_q == OST_PULSE_B)
            delay_q <= max32(delay_q, shared_time_pulse_b ? 32'h0 : elapsed_q[1]);
      end
   end

   // processing time bounds the shortest cycle
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mincyc_q <= `OST_CYCLE_RST;
         calc_q   <= 32'h0;
      end
      else if (start_meas)
      begin
         mincyc_q <= 32'h0;
         calc_q   <= 32'h0;
      end
      else if (meas_q == OST_MEAS && cycle_done && busy_q)
      begin
         mincyc_q <= max32(mincyc_q, elapsed_q[2] + NS);
         if (shared)
            calc_q <= max32(calc_q, elapsed_q[2] + NS);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // diagnostics
   // missed buffer event
   assign inc[0] = running_state && shared && shared_time_pulse_a && a_seen_q
                   && !got_buf_q && !output_buffer_event;
   // overrun, or early start against the cycle entry
   assign inc[1] = running_state && trig && started_q
                   && (busy_q || (mode_q != OST_FREE && elapsed_q[2] + NS < cycle_q));
   assign inc[2] = (mode_q == OST_PULSE_B) && shared_time_pulse_b && a_seen_q
                   && (elapsed_q[0] < calc_q);

   for (genvar i = 0; i < 3; i++)
   begin : g_cnt
      ost_event_cnt #(.W(CNT_W)) u_cnt
      (
         .clk   (clk),
         .nrst  (nrst),
         .inc   (inc[i]),
         .count (cnt[i])
      );
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         sync_fault <= 1'b0;
      else if (running_state && |inc)
         sync_fault <= 1'b1;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         meas_active <= 1'b0;
      else
         meas_active <= (meas_q == OST_MEAS) ? ~(wr_cmd_ok & ~od_req.wdata[0]) : start_meas;
   end

   ////////////////////////////////////////////////////////////////////////////
   // dictionary read mux
   always_comb
   begin
      rd_val   = 32'h0;
      rd_known = 1'b1;
      case (od_req.sub)
         `OST_SUB_COUNT:   rd_val = {24'h0, `OST_COUNT_VAL};
         `OST_SUB_MODE:    rd_val = {30'h0, mode_q};
         `OST_SUB_CYCLE:   rd_val = cycle_q;
         `OST_SUB_SHIFT:   rd_val = shift_q;
         `OST_SUB_SUPP:    rd_val = {16'h0, `OST_SUPP_VAL};
         `OST_SUB_MINCYC:  rd_val = mincyc_q;
         `OST_SUB_CALC:    rd_val = calc_q;
         `OST_SUB_CMD:     rd_val = {16'h0, cmd_q};
         `OST_SUB_DELAY:   rd_val = delay_q;
         `OST_SUB_MISSED:  rd_val = 32'(cnt[0]);
         `OST_SUB_OVERRUN: rd_val = 32'(cnt[1]);
         `OST_SUB_SHORT:   rd_val = 32'(cnt[2]);
         `OST_SUB_FAULT:   rd_val = {31'h0, sync_fault};
         default:          rd_known = 1'b0;
      endcase
   end

   // read-only entries abort a write rather than ignore it silently
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         od_rsp <= '0;
      else
      begin
         od_rsp.ack   <= od_req.rd | od_req.wr;
         od_rsp.abort <= (od_req.rd && !rd_known)
                         || (od_req.wr && !wr_mode_ok && !wr_cmd_ok
                             && !is_sub(od_req.sub, `OST_SUB_CYCLE));
         od_rsp.rdata <= od_req.rd ? rd_val : 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   AST_PULSE_A_DRIVE: assert property (
      mode_q == OST_PULSE_A && shared_time_pulse_a |=> outputs_drive)
      else $error("pulse A did not drive outputs");
   AST_PULSE_B_DRIVE: assert property (
      mode_q == OST_PULSE_B && !shared_time_pulse_b |=> !outputs_drive)
      else $error("outputs driven without pulse B");
   AST_BUF_DRIVE: assert property (
      mode_q == OST_BUF && output_buffer_event |=> outputs_drive)
      else $error("buffer event did not drive outputs");
   AST_FREE_PERIOD: assert property (
      mode_q == OST_FREE && $stable(cycle_q) && tick |-> elapsed_q[2] + NS >= cycle_q)
      else $error("local timer period too short");
   AST_RESTART_CLEARS: assert property (
      start_meas |=> shift_q == 32'h0 && delay_q == 32'h0 && mincyc_q == 32'h0)
      else $error("maxima not cleared on start");
   AST_MAX_HOLDS: assert property (
      meas_q == OST_MEAS && !start_meas |=> shift_q >= $past(shift_q))
      else $error("measured maximum decreased");
   AST_OVERRUN_CNT: assert property (
      inc[1] && !(&cnt[1]) |=> cnt[1] == $past(cnt[1]) + 1'b1)
      else $error("overrun not counted");
   AST_MISSED_CNT: assert property (
      running_state && mode_q == OST_PULSE_A && shared_time_pulse_a && a_seen_q
      && !got_buf_q && !output_buffer_event && !(&cnt[0])
      |=> cnt[0] == $past(cnt[0]) + 1'b1)
      else $error("missed event not counted");
   AST_SHORT_CNT: assert property (
      mode_q != OST_PULSE_B |=> cnt[2] == $past(cnt[2]))
      else $error("spacing counted outside pulse B mode");
   AST_FAULT_SET: assert property (
      running_state && |inc |=> sync_fault [*2])
      else $error("fault flag not set and held");
   AST_RO_WRITE: assert property (
      od_req.wr && is_sub(od_req.sub, `OST_SUB_SHIFT) |=> od_rsp.ack && od_rsp.abort)
      else $error("write to read-only entry accepted");
   AST_COUNT_READ: assert property (
      od_req.rd && is_sub(od_req.sub, `OST_SUB_COUNT)
      |=> od_rsp.rdata == {24'h0, `OST_COUNT_VAL} && !od_rsp.abort)
      else $error("count entry wrong");
   AST_CMD_STATE: assert property (
      wr_cmd_ok |=> (meas_q == OST_MEAS) == cmd_q[0])
      else $error("command and measurement disagree");

   COV_MEAS_START: cover property (start_meas ##1 meas_q == OST_MEAS);
   COV_OVERRUN:    cover property (inc[1]);
   COV_PULSE_B:    cover property (mode_q == OST_PULSE_B && outputs_drive);
   COV_FAULT:      cover property ($rose(sync_fault));
endmodule

/* File: ost_master_model.sv */
// Purpose: bus master side of the dictionary port, one access at a time
// Assumes: called just after a rising edge, returns just after one
// Notes:   released address and data lines show the inverse of the last value
`timescale 1ns/1ns
module ost_master_model
   import ost_pkg::*;
(
   input  wire logic        clk,
   input  wire ost_od_rsp_t od_rsp,
   output ost_od_req_t      od_req
);
   initial od_req = '0;
   ////////////////////////////////////////////////////////////
   // command sent as one whole word
   task automatic access(input logic w, input logic [7:0] sub, input logic [31:0] wd,
                         output ost_od_rsp_t rsp);
      od_req = '{rd: !w, wr: w, sub: sub, wdata: wd};
      @(posedge clk);
      #1;
      // strobe is one cycle wide, the answer stands in the cycle after it
      od_req = '{rd: 1'b0, wr: 1'b0, sub: ~sub, wdata: ~wd};
      rsp = '0;
      if (od_rsp.ack === 1'b1)
         rsp = od_rsp;
      // one edge passes so the next strobe never rises in this time step
      @(posedge clk);
      #1;
   endtask
endmodule

/* File: tb_output_sync_parameters.sv */
// Purpose: self-checking bench for the output sync parameter set
// Assumes: inputs change 1 ns after the rising edge
// Notes:   register rows first, then sync sources, measurement, diagnostics
`timescale 1ns/1ns
module tb_output_sync_parameters
   import ost_pkg::*;
;
   typedef struct packed {logic w; logic [7:0] sub; logic [31:0] wd; logic ab;
                          logic [31:0] exp;} ost_row_t;
   logic        clk;
   logic        nrst;
   ost_od_req_t od_req;
   ost_od_rsp_t od_rsp;
   ost_od_rsp_t rsp;
   logic        running_state;
   logic        output_buffer_event;
   logic        shared_time_pulse_a;
   logic        shared_time_pulse_b;
   logic        cycle_done;
   logic        outputs_drive;
   logic        sync_fault;
   logic        meas_active;
   int          n_mismatch = 0;
   int          n_checks = 0;
   // reset values first, then a read of an unused place and refused writes
   ost_row_t    rows [19] = '{
      '{1'b0, 8'h00, 32'h0, 1'b0, 32'h00000020}, '{1'b0, 8'h01, 32'h0, 1'b0, 32'h00000000},
      '{1'b0, 8'h02, 32'h0, 1'b0, 32'h000186a0}, '{1'b0, 8'h03, 32'h0, 1'b0, 32'h00000000},
      '{1'b0, 8'h04, 32'h0, 1'b0, 32'h0000c007}, '{1'b0, 8'h05, 32'h0, 1'b0, 32'h000186a0},
      '{1'b0, 8'h06, 32'h0, 1'b0, 32'h00000000}, '{1'b0, 8'h08, 32'h0, 1'b0, 32'h00000000},
      '{1'b0, 8'h09, 32'h0, 1'b0, 32'h00000000}, '{1'b0, 8'h0b, 32'h0, 1'b0, 32'h00000000},
      '{1'b0, 8'h0c, 32'h0, 1'b0, 32'h00000000}, '{1'b0, 8'h0d, 32'h0, 1'b0, 32'h00000000},
      '{1'b0, 8'h20, 32'h0, 1'b0, 32'h00000000}, '{1'b0, 8'h07, 32'h0, 1'b1, 32'h00000000},
      '{1'b1, 8'h04, 32'h1, 1'b1, 32'h00000000}, '{1'b1, 8'h01, 32'h4, 1'b1, 32'h00000000},
      '{1'b1, 8'h08, 32'h2, 1'b1, 32'h00000000}, '{1'b1, 8'h00, 32'h5, 1'b1, 32'h00000000},
      '{1'b0, 8'h01, 32'h0, 1'b0, 32'h00000000}};

   ost_output_sync #(.CNT_W(16)) dut
   (
      .clk                 (clk),
      .nrst                (nrst),
      .od_req              (od_req),
      .od_rsp              (od_rsp),
      .running_state       (running_state),
      .output_buffer_event (output_buffer_event),
      .shared_time_pulse_a (shared_time_pulse_a),
      .shared_time_pulse_b (shared_time_pulse_b),
      .cycle_done          (cycle_done),
      .outputs_drive       (outputs_drive),
      .sync_fault          (sync_fault),
      .meas_active         (meas_active)
   );
   ost_master_model mst
   (
      .clk    (clk),
      .od_rsp (od_rsp),
      .od_req (od_req)
   );

   initial clk = 1'b0;
   always #10 clk = ~clk;
   ////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n)
      begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic pulse(input logic a, input logic b, input logic ev, input logic done);
      {shared_time_pulse_a, shared_time_pulse_b, output_buffer_event, cycle_done} = {a, b, ev, done};
      step(1);
      {shared_time_pulse_a, shared_time_pulse_b, output_buffer_event, cycle_done} = 4'h0;
   endtask
   task automatic rd(input logic [7:0] sub, input logic [31:0] exp);
      mst.access(1'b0, sub, 32'h0, rsp);
      chk("read ack", rsp.ack, 32'h1);
      chk("read data", rsp.rdata, exp);
   endtask
   task automatic wr(input logic [7:0] sub, input logic [31:0] wd);
      mst.access(1'b1, sub, wd, rsp);
      chk("write abort", {rsp.ack, rsp.abort}, 32'h2);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // run is under a thousand cycles, so this only cuts a hang
   initial
   begin
      #100000;
      n_mismatch++;
      tally_and_finish;
   end

   initial
   begin
      int m;
      int s;
      int n;
      nrst = 1'b0;
      running_state = 1'b0;
      {shared_time_pulse_a, shared_time_pulse_b, output_buffer_event, cycle_done} = 4'h0;
      repeat (10) @(posedge clk);
      #1;
      nrst = 1'b1;
      foreach (rows[i])
      begin
         mst.access(rows[i].w, rows[i].sub, rows[i].wd, rsp);
         chk("row ack", rsp.ack, 32'h1);
         chk("row abort", rsp.abort, rows[i].ab);
         chk("row data", rsp.rdata, rows[i].exp);
      end
      // only the selected source drives the outputs
      for (m = 1; m < 4; m++)
      begin
         wr(8'h01, m);
         wr(8'h02, 32'h3e8 * m);
         rd(8'h02, 32'h3e8 * m);
         for (s = 0; s < 3; s++)
         begin
            pulse(s == 1, s == 2, s == 0, 1'b0);
            chk("drive", outputs_drive, s + 1 == m);
            step(1);
            chk("drive end", outputs_drive, 32'h0);
         end
      end
      wr(8'h02, 32'hc8);
      wr(8'h01, 32'h0);
      n = 0;
      while (outputs_drive !== 1'b1 && n < 30)
      begin
         step(1);
         n++;
      end
      n = 0;
      do
      begin
         step(1);
         n++;
      end while (outputs_drive !== 1'b1 && n < 30);
      chk("tick gap", n, 32'ha);
      // maxima measured in pulse b mode
      wr(8'h01, 32'h3);
      wr(8'h08, 32'h1);
      step(1);
      chk("meas on", meas_active, 32'h1);
      pulse(1'b1, 1'b0, 1'b0, 1'b0);
      step(2);
      pulse(1'b0, 1'b1, 1'b0, 1'b0);
      step(4);
      pulse(1'b0, 1'b0, 1'b0, 1'b1);
      step(2);
      rd(8'h03, 32'h28);
      rd(8'h06, 32'h64);
      rd(8'h05, 32'h64);
      rd(8'h09, 32'h0);
      pulse(1'b1, 1'b0, 1'b0, 1'b0);
      step(2);
      pulse(1'b0, 1'b1, 1'b0, 1'b0);
      step(2);
      rd(8'h0d, 32'h1);
      chk("fault stopped", sync_fault, 32'h0);
      wr(8'h08, 32'h0);
      step(1);
      chk("meas off", meas_active, 32'h0);
      wr(8'h08, 32'h1);
      step(1);
      rd(8'h03, 32'h0);
      rd(8'h05, 32'h0);
      wr(8'h08, 32'h0);
      // faults in running state, pulse a mode
      wr(8'h01, 32'h2);
      wr(8'h02, 32'hc8);
      running_state = 1'b1;
      pulse(1'b0, 1'b0, 1'b1, 1'b1);
      step(1);
      pulse(1'b1, 1'b0, 1'b0, 1'b0);
      step(2);
      pulse(1'b0, 1'b0, 1'b1, 1'b1);
      step(12);
      pulse(1'b1, 1'b0, 1'b0, 1'b0);
      step(12);
      chk("fault idle", sync_fault, 32'h0);
      pulse(1'b1, 1'b0, 1'b0, 1'b0);
      step(2);
      chk("fault set", sync_fault, 32'h1);
      pulse(1'b0, 1'b0, 1'b1, 1'b1);
      step(1);
      pulse(1'b1, 1'b0, 1'b0, 1'b0);
      step(2);
      rd(8'h0b, 32'h1);
      rd(8'h0c, 32'h2);
      rd(8'h20, 32'h1);
      // second reset in mid-run
      nrst = 1'b0;
      step(2);
      nrst = 1'b1;
      chk("fault reset", sync_fault, 32'h0);
      rd(8'h01, 32'h0);
      rd(8'h0c, 32'h0);
      tally_and_finish;
   end
endmodule
